// ---- common/tcss_pkg.sv ----
// package: word layouts, codes and register map of the tape control status/search block
package tcss_pkg;
  localparam int TCSS_WORD_W = 30;
  localparam int TCSS_CODE_LSB = 24;
  localparam int TCSS_CODE_MSB = 29;
  localparam int TCSS_UNIT_LSB = 0;
  localparam int TCSS_UNIT_MSB = 3;
  localparam int TCSS_EI_W = 6;
  // error indicator bit positions
  localparam int TCSS_EI_SKEW = 0;
  localparam int TCSS_EI_PARITY = 1;
  localparam int TCSS_EI_FRAME = 2;
  localparam int TCSS_EI_INTLK = 3;
  localparam int TCSS_EI_PILEUP = 4;
  localparam int TCSS_EI_ILLEGAL = 5;
  // status codes (octal)
  localparam logic [5:0] TCSS_SC_TERMINATED = 6'o64;
  localparam logic [5:0] TCSS_SC_ILLEGAL = 6'o50;
  localparam logic [5:0] TCSS_SC_MANUAL = 6'o74;
  localparam logic [5:0] TCSS_SC_REWINDING = 6'o10;
  localparam logic [5:0] TCSS_SC_MAINT = 6'o30;
  localparam logic [5:0] TCSS_SC_EOF = 6'o34;
  localparam logic [5:0] TCSS_SC_REPEAT = 6'o60;
  localparam logic [5:0] TCSS_SC_BADBLOCK = 6'o54;
  localparam logic [5:0] TCSS_SC_FRAMECNT = 6'o70;
  localparam logic [5:0] TCSS_SC_MARKER = 6'o44;
  localparam logic [5:0] TCSS_SC_NORMAL = 6'o40;
  localparam logic [5:0] TCSS_SC_OTHERCU = 6'o14;
  // operation codes (octal)
  localparam logic [5:0] TCSS_OP_TERMINATE = 6'o23;
  localparam logic [5:0] TCSS_OP_TERMINATE_I = 6'o33;
  localparam logic [5:0] TCSS_OP_MSRCH_F = 6'o46;
  localparam logic [5:0] TCSS_OP_MSRCH_B = 6'o66;
  localparam logic [5:0] TCSS_OP_SRCH_F = 6'o45;
  localparam logic [5:0] TCSS_OP_SRCH_B = 6'o65;
  // apb register byte addresses
  localparam logic [7:0] TCSS_A_CMD = 8'h00;
  localparam logic [7:0] TCSS_A_STATUS = 8'h04;
  localparam logic [7:0] TCSS_A_EVENT = 8'h08;
  localparam logic [7:0] TCSS_A_CFG = 8'h0C;
  localparam logic [7:0] TCSS_A_UNIT = 8'h10;
  localparam logic [7:0] TCSS_A_SRCHWORD = 8'h14;
  localparam logic [7:0] TCSS_A_OPSTATE = 8'h18;
  localparam logic [7:0] TCSS_A_FRAMES = 8'h1C;
  // event register bits
  localparam int TCSS_EV_CUTOFF = 0;
  localparam int TCSS_EV_SIGFAULT = 1;
  localparam int TCSS_EV_LOADPT = 2;
  localparam int TCSS_EV_PWRLOSS = 3;
  localparam int TCSS_EV_FILESEP = 4;
  localparam int TCSS_EV_REPARITY = 5;
  localparam int TCSS_EV_RESUMEIN = 6;
  localparam int TCSS_EV_RESUMEOUT = 7;
  localparam int TCSS_EV_WRERR = 8;
  localparam int TCSS_EV_BADPAT = 9;
  localparam int TCSS_EV_EOTWARN = 10;
  localparam int TCSS_EV_DONE = 11;
  localparam int TCSS_EV_SKEW = 12;
  localparam int TCSS_EV_PARITY = 13;
  localparam int TCSS_EV_PILEUP = 14;
  localparam int TCSS_EV_W = 15;
  // config bits
  localparam int TCSS_CFG_DUAL = 0;
  localparam int TCSS_CFG_SECOND = 1;
  localparam int TCSS_CFG_FIVEFR = 2;
  localparam logic [2:0] TCSS_CFG_RST = 3'h0;
  localparam int TCSS_UNITS = 16;

  typedef enum logic [1:0] {TCSS_W_CMD, TCSS_W_MASK, TCSS_W_IDENT} tcss_word_t;

  typedef struct packed {
    logic [5:0] status_code_field;
    logic [17:0] spare;
    logic [5:0] error_indicator_field;
  } tcss_status_t;

  typedef struct packed {
    logic [5:0] operation_code_field;
    logic [19:0] spare;
    logic [3:0] unit;
  } tcss_cmd_t;
endpackage : tcss_pkg

// ---- hdl/tcss_status_gen.sv ----
// status word encoder: prioritised status code plus error indicator bits
`timescale 1ns/10ps
`default_nettype none
module tcss_status_gen import tcss_pkg::*; (
  input wire logic [TCSS_EV_W-1:0] ev,
  input wire logic illegal_op,
  input wire logic unit_intlk,
  input wire logic unit_rewinding,
  input wire logic other_cu,
  input wire logic frame_bad,
  output logic report,
  output tcss_status_t word
);
  always_comb begin
    word = '0;
    report = 1'b1;
    // one code per word; abnormal causes outrank normal completion
    if (illegal_op) begin
      word.status_code_field = TCSS_SC_ILLEGAL;
    end else if (other_cu) begin
      word.status_code_field = TCSS_SC_OTHERCU;
    end else if (unit_intlk) begin
      word.status_code_field = TCSS_SC_MANUAL;
    end else if (unit_rewinding) begin
      word.status_code_field = TCSS_SC_REWINDING;
    end else if (ev[TCSS_EV_CUTOFF]) begin
      word.status_code_field = TCSS_SC_TERMINATED;
    end else if (ev[TCSS_EV_SIGFAULT] | ev[TCSS_EV_LOADPT] | ev[TCSS_EV_PWRLOSS]) begin
      word.status_code_field = TCSS_SC_MAINT;
    end else if (ev[TCSS_EV_EOTWARN]) begin
      word.status_code_field = TCSS_SC_MARKER;
    end else if (ev[TCSS_EV_WRERR] | ev[TCSS_EV_BADPAT]) begin
      word.status_code_field = TCSS_SC_BADBLOCK;
    end else if (frame_bad) begin
      word.status_code_field = TCSS_SC_FRAMECNT;
    end else if (ev[TCSS_EV_REPARITY] | ev[TCSS_EV_RESUMEIN] | ev[TCSS_EV_RESUMEOUT]) begin
      word.status_code_field = TCSS_SC_REPEAT;
    end else if (ev[TCSS_EV_FILESEP]) begin
      word.status_code_field = TCSS_SC_EOF;
    end else if (ev[TCSS_EV_DONE]) begin
      word.status_code_field = TCSS_SC_NORMAL;
    end else begin
      report = 1'b0;
    end
    word.error_indicator_field[TCSS_EI_SKEW] = ev[TCSS_EV_SKEW];
    word.error_indicator_field[TCSS_EI_PARITY] = ev[TCSS_EV_PARITY] | ev[TCSS_EV_WRERR];
    word.error_indicator_field[TCSS_EI_FRAME] = frame_bad;
    word.error_indicator_field[TCSS_EI_INTLK] = unit_intlk;
    word.error_indicator_field[TCSS_EI_PILEUP] = ev[TCSS_EV_PILEUP];
    word.error_indicator_field[TCSS_EI_ILLEGAL] = illegal_op;
  end
endmodule : tcss_status_gen
`default_nettype wire

// ---- hdl/tcss_top.sv ----
// tape control unit word logic: command decode, masked search, status words, apb registers
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module tcss_top import tcss_pkg::*; #(
  parameter int UNITS = TCSS_UNITS
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [UNITS-1:0] UNIT_INTLK,
  input wire logic [UNITS-1:0] UNIT_REWIND,
  input wire logic [UNITS-1:0] UNIT_OTHER_CU,
  input wire logic PROC_SEL,
  input wire logic BLK_WORD_VLD,
  input wire logic [TCSS_WORD_W-1:0] BLK_WORD,
  input wire logic FRAME_STB,
  input wire logic BLK_END,
  output logic [TCSS_WORD_W-1:0] STATUS_WORD,
  output logic EXT_INT,
  output logic SEARCH_HIT,
  output logic [3:0] UNIT_SEL,
  output logic TAPE_BACKWARD,
  output logic WRITE_ACTIVE,
  output logic [2:0] FRAMES_PER_WORD,
  output logic OWNER_PROC
);
  logic wr_en;
  logic rd_en;
  logic [2:0] cfg_r;
  tcss_word_t wstate_r;
  tcss_cmd_t cmd_r;
  logic [TCSS_WORD_W-1:0] mask_r;
  logic [TCSS_WORD_W-1:0] ident_r;
  logic busy_r;
  logic search_r;
  logic int_req_r;
  logic owner_r;
  logic [TCSS_EV_W-1:0] ev_r;
  logic illegal_r;
  logic intlk_r;
  logic rewind_r;
  logic othercu_r;
  logic frame_bad_r;
  logic [15:0] frame_cnt_r;
  logic hit_r;
  logic [TCSS_WORD_W-1:0] status_r;
  logic ext_int_r;
  logic report;
  tcss_status_t sword;
  tcss_cmd_t cmd_in;
  logic [5:0] op;
  logic op_legal;
  logic op_write;
  logic [TCSS_WORD_W-1:0] blk_diff;
  logic pending;
  logic from_owner;

  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_en = PSEL & PENABLE & ~PWRITE;
  assign PREADY = 1'b1;
  assign cmd_in = tcss_cmd_t'(PWDATA[TCSS_WORD_W-1:0]);
  assign op = cmd_in.operation_code_field;
  assign from_owner = PROC_SEL == owner_r;

  always_comb begin
    op_legal = 1'b1;
    unique case (op[2:0])
      3'h1, 3'h2, 3'h3: op_legal = op[5:4] != 2'h3 || op[3] == 1'b0;
      default: op_legal = 1'b1;
    endcase
    // recognised function set; others are refused with an illegal code
    unique case (op)
      6'o01, 6'o11, 6'o02, 6'o12, 6'o03, 6'o13, 6'o41, 6'o51, 6'o61, 6'o71,
      6'o42, 6'o52, 6'o62, 6'o72, 6'o45, 6'o55, 6'o65, 6'o75, 6'o46, 6'o56,
      6'o66, 6'o76, 6'o20, 6'o30, 6'o21, 6'o31, 6'o40, 6'o50, 6'o23, 6'o33,
      6'o24, 6'o34, 6'o26, 6'o27, 6'o25, 6'o35: op_legal = 1'b1;
      default: op_legal = 1'b0;
    endcase
  end

  assign op_write = op[5:4] == 2'h0 && op[3:0] != 4'h0;
  // second form of the masked compare, kept apart so the hit check is not a copy
  assign blk_diff = (BLK_WORD & mask_r) ^ (ident_r & mask_r);
  assign pending = ev_r != '0 || illegal_r || intlk_r || rewind_r || othercu_r || frame_bad_r;

  tcss_status_gen u_gen (
    .ev(ev_r),
    .illegal_op(illegal_r),
    .unit_intlk(intlk_r),
    .unit_rewinding(rewind_r),
    .other_cu(othercu_r),
    .frame_bad(frame_bad_r),
    .report(report),
    .word(sword)
  );

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_r <= TCSS_CFG_RST;
    end else if (wr_en && PADDR == TCSS_A_CFG) begin
      cfg_r <= PWDATA[2:0];
    end
  end

  // command word sequencing; mask and identifier follow a masked search
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wstate_r <= TCSS_W_CMD;
      cmd_r <= '0;
      mask_r <= '0;
      ident_r <= '0;
      busy_r <= 1'b0;
      search_r <= 1'b0;
      int_req_r <= 1'b0;
      owner_r <= 1'b0;
    end else begin
      if (wr_en && PADDR == TCSS_A_CMD && from_owner) begin
        unique case (wstate_r)
          TCSS_W_CMD: begin
            cmd_r <= cmd_in;
            int_req_r <= op[3];
            if (op == TCSS_OP_MSRCH_F || op == TCSS_OP_MSRCH_B ||
                op == 6'o56 || op == 6'o76) begin
              wstate_r <= TCSS_W_MASK;
            end else if (op == TCSS_OP_SRCH_F || op == TCSS_OP_SRCH_B ||
                         op == 6'o55 || op == 6'o75) begin
              mask_r <= '1;
              wstate_r <= TCSS_W_IDENT;
            end
            if (op == 6'o24 || op == 6'o34) begin
              owner_r <= ~owner_r;
            end
            busy_r <= op_legal && !(op_write && cfg_r[TCSS_CFG_SECOND]);
          end
          TCSS_W_MASK: begin
            mask_r <= PWDATA[TCSS_WORD_W-1:0];
            wstate_r <= TCSS_W_IDENT;
          end
          TCSS_W_IDENT: begin
            ident_r <= PWDATA[TCSS_WORD_W-1:0];
            search_r <= 1'b1;
            wstate_r <= TCSS_W_CMD;
          end
        endcase
      end else if (wr_en && PADDR == TCSS_A_CMD && (op == 6'o26 || op == 6'o25)) begin
        owner_r <= PROC_SEL;
      end
      if (search_r && BLK_WORD_VLD && ((BLK_WORD ^ ident_r) & mask_r) == '0) begin
        search_r <= 1'b0;
      end
      if (report && !ext_int_r) begin
        busy_r <= 1'b0;
        search_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= search_r && BLK_WORD_VLD && ((BLK_WORD ^ ident_r) & mask_r) == '0;
    end
  end

  // frame count checked per block against four-frame packing; no check while five-frame packing is set
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      frame_cnt_r <= '0;
    end else if (BLK_END) begin
      frame_cnt_r <= '0;
    end else if (FRAME_STB) begin
      frame_cnt_r <= frame_cnt_r + 16'h0001;
    end
  end

  // condition flags; a new event wins over the clear at status send
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ev_r <= '0;
      illegal_r <= 1'b0;
      intlk_r <= 1'b0;
      rewind_r <= 1'b0;
      othercu_r <= 1'b0;
      frame_bad_r <= 1'b0;
    end else begin
      if (report && !ext_int_r) begin
        ev_r <= '0;
        illegal_r <= 1'b0;
        intlk_r <= 1'b0;
        rewind_r <= 1'b0;
        othercu_r <= 1'b0;
        frame_bad_r <= 1'b0;
      end
      if (wr_en && PADDR == TCSS_A_EVENT) begin
        ev_r <= ev_r | PWDATA[TCSS_EV_W-1:0];
        if (PWDATA[TCSS_EV_DONE] && !int_req_r) begin
          ev_r[TCSS_EV_DONE] <= 1'b0;
        end
      end
      if (wr_en && PADDR == TCSS_A_CMD && from_owner && wstate_r == TCSS_W_CMD) begin
        if (op == TCSS_OP_TERMINATE || op == TCSS_OP_TERMINATE_I) begin
          ev_r[TCSS_EV_CUTOFF] <= busy_r;
        end
        illegal_r <= !op_legal || (op_write && cfg_r[TCSS_CFG_SECOND]);
        intlk_r <= UNIT_INTLK[cmd_in.unit];
        rewind_r <= UNIT_REWIND[cmd_in.unit] && !UNIT_INTLK[cmd_in.unit];
        othercu_r <= cfg_r[TCSS_CFG_DUAL] && UNIT_OTHER_CU[cmd_in.unit];
      end
      if (BLK_END && frame_cnt_r[1:0] != 2'h0 && !cfg_r[TCSS_CFG_FIVEFR]) begin
        frame_bad_r <= 1'b1;
      end
    end
  end

  // interrupt held one cycle, then cleared; status word held until the next report
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      status_r <= '0;
      ext_int_r <= 1'b0;
    end else if (report && !ext_int_r) begin
      status_r <= sword;
      ext_int_r <= 1'b1;
    end else begin
      ext_int_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PRDATA <= '0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        TCSS_A_STATUS: PRDATA <= {2'h0, status_r};
        TCSS_A_EVENT: PRDATA <= {17'h0, ev_r};
        TCSS_A_CFG: PRDATA <= {29'h0, cfg_r};
        TCSS_A_UNIT: PRDATA <= {2'h0, cmd_r};
        TCSS_A_SRCHWORD: PRDATA <= {2'h0, mask_r};
        TCSS_A_OPSTATE: PRDATA <= {26'h0, owner_r, pending, search_r, busy_r, wstate_r};
        TCSS_A_FRAMES: PRDATA <= {16'h0, frame_cnt_r};
        default: PRDATA <= '0;
      endcase
    end
  end

  always_comb begin
    PSLVERR = 1'b0;
    if (PSEL && PENABLE) begin
      PSLVERR = !(PADDR inside {TCSS_A_CMD, TCSS_A_STATUS, TCSS_A_EVENT, TCSS_A_CFG,
                                TCSS_A_UNIT, TCSS_A_SRCHWORD, TCSS_A_OPSTATE,
                                TCSS_A_FRAMES});
    end
  end

  assign STATUS_WORD = status_r;
  assign EXT_INT = ext_int_r;
  assign SEARCH_HIT = hit_r;
  assign UNIT_SEL = cmd_r.unit;
  assign TAPE_BACKWARD = cmd_r.operation_code_field[5:4] == 2'h3;
  assign WRITE_ACTIVE = busy_r && cmd_r.operation_code_field[5:4] == 2'h0 &&
                        cmd_r.operation_code_field[3:0] != 4'h0;
  assign FRAMES_PER_WORD = cfg_r[TCSS_CFG_FIVEFR] ? 3'h5 : 3'h4;
  assign OWNER_PROC = owner_r;

  chk_int_with_status: assert property (@(posedge CLK) disable iff (!NRST)
    $changed(status_r) |-> ext_int_r) else $error("status changed without interrupt");
  chk_int_one_cycle: assert property (@(posedge CLK) disable iff (!NRST)
    ext_int_r |=> !ext_int_r) else $error("interrupt held too long");
  chk_illegal_code: assert property (@(posedge CLK) disable iff (!NRST)
    illegal_r && !ext_int_r |=> ext_int_r && status_r[29:24] == TCSS_SC_ILLEGAL)
    else $error("illegal code not reported");
  chk_illegal_bit: assert property (@(posedge CLK) disable iff (!NRST)
    ext_int_r && status_r[29:24] == TCSS_SC_ILLEGAL |-> status_r[TCSS_EI_ILLEGAL])
    else $error("illegal bit missing");
  chk_search_hit: assert property (@(posedge CLK) disable iff (!NRST)
    search_r && BLK_WORD_VLD && ((BLK_WORD ^ ident_r) & mask_r) == '0 |=> hit_r)
    else $error("masked match missed");
  chk_no_false_hit: assert property (@(posedge CLK) disable iff (!NRST)
    hit_r |-> $past(blk_diff) == '0 && $past(BLK_WORD_VLD)) else $error("false hit");
  chk_mask_order: assert property (@(posedge CLK) disable iff (!NRST)
    wstate_r == TCSS_W_MASK && wr_en && PADDR == TCSS_A_CMD && from_owner
    |=> wstate_r == TCSS_W_IDENT) else $error("mask not followed by identifier");
  chk_second_no_write: assert property (@(posedge CLK) disable iff (!NRST)
    cfg_r[TCSS_CFG_SECOND] |-> !WRITE_ACTIVE) else $error("second unit writing");
  chk_status_fields: assert property (@(posedge CLK) disable iff (!NRST)
    ext_int_r |-> status_r[23:6] == '0) else $error("status spare bits set");
  cov_masked: cover property (@(posedge CLK) disable iff (!NRST) hit_r);
  cov_normal: cover property (@(posedge CLK) disable iff (!NRST)
    ext_int_r && status_r[29:24] == TCSS_SC_NORMAL);
  cov_term: cover property (@(posedge CLK) disable iff (!NRST)
    ext_int_r && status_r[29:24] == TCSS_SC_TERMINATED);
endmodule : tcss_top
`default_nettype wire

// ---- dv/tcss_proc_model.sv ----
// processor channel model: apb master plus collector of status words
`timescale 1ns/10ps
`default_nettype none
module tcss_proc_model import tcss_pkg::*; (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_int,
  input wire logic [TCSS_WORD_W-1:0] status_word
);
  int n_int = 0;
  logic [TCSS_WORD_W-1:0] last_st = '0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // a status word is only taken while the interrupt line stands beside it
  always_ff @(posedge clk) begin
    if (ext_int === 1'b1) begin
      last_st <= status_word;
      n_int <= n_int + 1;
    end
  end
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr
  task cmd(input logic [5:0] op, input logic [3:0] unit);
    wr(TCSS_A_CMD, {2'h0, op, 20'h0, unit});
  endtask : cmd
  task msearch(input logic [5:0] op, input logic [29:0] mask, input logic [29:0] ident);
    cmd(op, 4'h0);
    wr(TCSS_A_CMD, {2'h0, mask});
    wr(TCSS_A_CMD, {2'h0, ident});
  endtask : msearch
endmodule : tcss_proc_model
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench of the tape control status/search block
`timescale 1ns/10ps
`default_nettype none
module testbench import tcss_pkg::*;;
  typedef struct {logic [5:0] op; logic [3:0] unit; logic [2:0] lvl;
    logic [14:0] ev; logic [5:0] code; logic [5:0] ei;} tcss_row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, ext_int, hit, bwd, wact, owner;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] intlk = '0, rewind = '0, othcu = '0;
  logic proc_sel = 1'b0, vld = 1'b0, frame = 1'b0, blk_end = 1'b0, err;
  logic [29:0] blk_word = '0, status_word;
  logic [3:0] unit_sel;
  logic [2:0] fpw;
  int n_fail = 0, cmp_count = 0, cyc = 0, n_hit = 0;
  tcss_row_t rows [16] = '{
    '{6'o77, 4'h0, 3'h0, 15'h0000, 6'o50, 6'h20}, '{6'o41, 4'h3, 3'h1, 15'h0000, 6'o74, 6'h08},
    '{6'o41, 4'h4, 3'h2, 15'h0000, 6'o10, 6'h00}, '{6'o41, 4'h6, 3'h4, 15'h0000, 6'o14, 6'h00},
    '{6'o51, 4'h1, 3'h0, 15'h0800, 6'o40, 6'h00}, '{6'o00, 4'h0, 3'h0, 15'h1001, 6'o64, 6'h01},
    '{6'o00, 4'h0, 3'h0, 15'h0002, 6'o30, 6'h00}, '{6'o00, 4'h0, 3'h0, 15'h0004, 6'o30, 6'h00},
    '{6'o00, 4'h0, 3'h0, 15'h0008, 6'o30, 6'h00}, '{6'o00, 4'h0, 3'h0, 15'h0010, 6'o34, 6'h00},
    '{6'o00, 4'h0, 3'h0, 15'h0020, 6'o60, 6'h00}, '{6'o00, 4'h0, 3'h0, 15'h4040, 6'o60, 6'h10},
    '{6'o00, 4'h0, 3'h0, 15'h0080, 6'o60, 6'h00}, '{6'o00, 4'h0, 3'h0, 15'h2100, 6'o54, 6'h02},
    '{6'o00, 4'h0, 3'h0, 15'h0200, 6'o54, 6'h00}, '{6'o00, 4'h0, 3'h0, 15'h0400, 6'o44, 6'h00}};

  initial begin
    forever #2 clk = ~clk;
  end

  tcss_top uut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .UNIT_INTLK(intlk), .UNIT_REWIND(rewind), .UNIT_OTHER_CU(othcu), .PROC_SEL(proc_sel),
    .BLK_WORD_VLD(vld), .BLK_WORD(blk_word), .FRAME_STB(frame), .BLK_END(blk_end),
    .STATUS_WORD(status_word), .EXT_INT(ext_int), .SEARCH_HIT(hit), .UNIT_SEL(unit_sel),
    .TAPE_BACKWARD(bwd), .WRITE_ACTIVE(wact), .FRAMES_PER_WORD(fpw), .OWNER_PROC(owner));

  tcss_proc_model u_proc (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_int(ext_int), .status_word(status_word));

  always @(posedge clk) begin
    cyc++;
    if (hit === 1'b1) n_hit++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  task cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task exp_st(input logic [5:0] code, input logic [5:0] ei);
    int n0;
    n0 = u_proc.n_int;
    for (int i = 0; i < 20 && u_proc.n_int == n0; i++) @(posedge clk);
    cmp("status count", n0 + 1, u_proc.n_int);
    cmp("status code", code, u_proc.last_st[29:24]);
    cmp("error bits", ei, u_proc.last_st[5:0]);
  endtask : exp_st
  task exp_none();
    int n0;
    n0 = u_proc.n_int;
    repeat (8) @(posedge clk);
    cmp("no status", n0, u_proc.n_int);
  endtask : exp_none
  task pulses(input int n);
    repeat (n) begin
      @(posedge clk) frame <= 1'b1;
      @(posedge clk) frame <= 1'b0;
    end
    @(posedge clk) blk_end <= 1'b1;
    @(posedge clk) blk_end <= 1'b0;
  endtask : pulses
  task blk(input logic [29:0] w, input int hits);
    @(posedge clk) blk_word <= w;
    vld <= 1'b1;
    @(posedge clk) vld <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("search hits", hits, n_hit);
  endtask : blk
  task test_done();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    cmp("frames per word", 3'd4, fpw);
    u_proc.apb(1'b0, TCSS_A_CFG, 32'h0, rd, err);
    cmp("cfg reset", 32'h0, rd);
    u_proc.apb(1'b0, 8'h20, 32'h0, rd, err);
    cmp("unmapped err", 1'b1, err);
    cmp("unmapped data", 32'h0, rd);
    u_proc.wr(TCSS_A_CFG, 32'h1);
    foreach (rows[i]) begin
      @(posedge clk)
        {othcu[rows[i].unit], rewind[rows[i].unit], intlk[rows[i].unit]} <= rows[i].lvl;
      if (rows[i].op != 6'o00) u_proc.cmd(rows[i].op, rows[i].unit);
      if (rows[i].ev != 15'h0) u_proc.wr(TCSS_A_EVENT, {17'h0, rows[i].ev});
      exp_st(rows[i].code, rows[i].ei);
      if (rows[i].op == 6'o51) cmp("unit select", rows[i].unit, unit_sel);
      @(posedge clk) {othcu, rewind, intlk} <= '0;
    end
    // interlock on an unselected unit must not be reported
    @(posedge clk) intlk[4] <= 1'b1;
    u_proc.cmd(6'o41, 4'h3);
    exp_none();
    // done event after a command without interrupt request stays silent
    u_proc.wr(TCSS_A_EVENT, 32'h800);
    exp_none();
    @(posedge clk) intlk <= '0;
    u_proc.cmd(6'o41, 4'h2);
    pulses(5);
    exp_st(6'o70, 6'h04);
    pulses(8);
    exp_none();
    u_proc.msearch(6'o46, 30'h0000FFFF, 30'h00001234);
    blk(30'h3FFF1235, 0);
    blk(30'h2AAA1234, 1);
    u_proc.wr(TCSS_A_CFG, 32'h3);
    u_proc.cmd(6'o01, 4'h1);
    exp_st(6'o50, 6'h20);
    u_proc.cmd(6'o61, 4'h1);
    exp_none();
    cmp("backward", 1'b1, bwd);
    cmp("write off", 1'b0, wact);
    u_proc.wr(TCSS_A_CFG, 32'h1);
    u_proc.cmd(6'o01, 4'h1);
    repeat (2) @(posedge clk);
    cmp("write on", 1'b1, wact);
    cmp("forward", 1'b0, bwd);
    u_proc.cmd(6'o23, 4'h1);
    exp_st(6'o64, 6'h00);
    u_proc.wr(TCSS_A_CFG, 32'h4);
    repeat (2) @(posedge clk);
    cmp("five frames", 3'd5, fpw);
    @(posedge clk) proc_sel <= 1'b1;
    u_proc.cmd(6'o77, 4'h0);
    exp_none();
    cmp("owner kept", 1'b0, owner);
    u_proc.cmd(6'o26, 4'h0);
    repeat (2) @(posedge clk);
    cmp("owner taken", 1'b1, owner);
    // mid-run reset must drop ownership, config and the last status word
    @(posedge clk) nrst <= 1'b0;
    @(posedge clk);
    cmp("reset frames", 3'd4, fpw);
    cmp("reset owner", 1'b0, owner);
    cmp("reset status", 30'h0, status_word);
    @(posedge clk) nrst <= 1'b1;
    u_proc.apb(1'b0, TCSS_A_CFG, 32'h0, rd, err);
    cmp("cfg after reset", 32'h0, rd);
    test_done();
  end
endmodule : testbench
`default_nettype wire
